// *** pkg/wdt_pkg.sv ***
// Package for the watchdog timeout reset block.
// Assumes one 100 MHz system clock standing in for the oscillator clock.
package wdt_pkg;
  // Register addresses on the plain register port
  localparam logic [15:0] WDT_ADDR_SERVICE = 16'hFFFF;
  localparam logic [15:0] WDT_ADDR_CONFIG  = 16'hFF00;
  localparam logic [15:0] WDT_ADDR_CAUSE   = 16'hFF01;
  localparam logic [15:0] WDT_ADDR_IRQ_ST  = 16'hFF02;
  localparam logic [15:0] WDT_ADDR_IRQ_EN  = 16'hFF03;
  localparam logic [15:0] WDT_ADDR_IRQ_CLR = 16'hFF04;
  // Field positions of the configuration register
  localparam int WDT_CFG_DISABLE = 0;
  localparam int WDT_CFG_RATE    = 1;
  // Field positions of cause and event registers
  localparam int WDT_CAUSE_WDT   = 0;
  localparam int WDT_EV_TIMEOUT  = 0;
  localparam int WDT_EV_SERVICE  = 1;
  // Reset values
  localparam logic [7:0] WDT_CONFIG_RST = 8'h00;
  localparam logic [7:0] WDT_CAUSE_RST  = 8'h00;
  localparam logic [1:0] WDT_IRQ_RST    = 2'h0;
  // Counter widths and timing counts in oscillator cycles
  localparam int WDT_PRE_W  = 12;
  localparam int WDT_WDT_W  = 6;
  localparam int WDT_SHORT_TAP = 7;
  localparam int WDT_PIN_LOW_CYC = 32;
  localparam int WDT_POR_CYC = 4096;
  localparam logic [5:0] WDT_PIN_LOW_LAST = 6'(WDT_PIN_LOW_CYC - 1);
  // States of the reset pin sequencer, one-hot
  typedef enum logic [1:0] {
    WDT_RUN   = 2'b01,
    WDT_PULSE = 2'b10
  } wdt_state_type;
endpackage

// *** tb/tb_watchdog_timeout_reset.sv ***
// Bench for the watchdog core: register reads, timeouts, inhibits.
// Assumes the short timeout so the run stays short; long rate does not time out within the run.
module tb_watchdog_timeout_reset;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] SVC = wdt_pkg::WDT_ADDR_SERVICE;
  localparam logic [15:0] CFG = wdt_pkg::WDT_ADDR_CONFIG;
  logic clk_sys, rst_b, tb_wr, reg_rd, vector_fetch, stop_mode;
  logic monitor_mode, break_active, irq_pin_high_volt;
  logic rst_pin_high_volt, sw_on;
  logic [15:0] tb_addr;
  logic [7:0] tb_wdata, reset_vector_low;
  wire logic reg_wr, sw_wr, rst_pin_out, rst_pin_oe_b, wdt_reset, irq;
  wire logic [15:0] reg_addr, sw_addr;
  wire logic [7:0] reg_wdata, sw_wdata, reg_rdata;
  int n_fail, cmp_count;
  //////////////////////////////////////////////////
  // Bench and software model share one write port
  assign reg_wr = tb_wr | sw_wr;
  assign reg_addr = sw_wr ? sw_addr : tb_addr;
  assign reg_wdata = sw_wr ? sw_wdata : tb_wdata;
  wdt_core uut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reset_vector_low(reset_vector_low),
    .vector_fetch(vector_fetch), .stop_mode(stop_mode),
    .monitor_mode(monitor_mode), .break_active(break_active),
    .irq_pin_high_volt(irq_pin_high_volt),
    .rst_pin_high_volt(rst_pin_high_volt), .rst_pin_out(rst_pin_out),
    .rst_pin_oe_b(rst_pin_oe_b), .wdt_reset(wdt_reset), .irq(irq));
  wdt_sw_model #(.PERIOD(3000)) sw (.clk_sys(clk_sys), .rst_b(rst_b),
    .active(sw_on), .sw_wr(sw_wr), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata));
  //////////////////////////////////////////////////
  task check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    tb_wr <= 1'b1;
    tb_addr <= a;
    tb_wdata <= d;
    @(posedge clk_sys);
    tb_wr <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe
  task rd_chk(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    tb_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask
  // Counts cycles with the reset raised; none are allowed
  task quiet(input int n);
    int hits;
    hits = 0;
    repeat (n) begin
      @(posedge clk_sys);
      #1 if (wdt_reset === 1'b1) hits++;
    end
    check({7'h00, hits != 0}, 8'h00);
  endtask
  // Bounded wait for the reset, then its width on the pin
  task measure(input int lo, input int hi);
    int n, w;
    n = 0;
    w = 0;
    while (wdt_reset !== 1'b1 && n < 13000) begin
      @(posedge clk_sys);
      #1 n++;
    end
    check({7'h00, n >= lo && n <= hi}, 8'h01);
    check({7'h00, rst_pin_oe_b}, 8'h00);
    check({7'h00, rst_pin_out}, 8'h00);
    while (wdt_reset === 1'b1 && w < 40) begin
      @(posedge clk_sys);
      #1 w++;
    end
    check(8'(w), 8'(wdt_pkg::WDT_PIN_LOW_CYC));
    check({7'h00, rst_pin_oe_b}, 8'h01);
  endtask
  task results;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  //////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Watchdog sized a little above the sum of all waits
  initial begin
    #1_000_000;
    n_fail++;
    results();
  end
  initial begin
    {rst_b, tb_wr, reg_rd, vector_fetch, stop_mode, sw_on} = '0;
    {monitor_mode, break_active, irq_pin_high_volt} = '0;
    rst_pin_high_volt = 1'b0;
    tb_addr = 16'h0000;
    tb_wdata = 8'h00;
    reset_vector_low = 8'hA5;
    n_fail = 0;
    cmp_count = 0;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd_chk(CFG, 8'h00);
    rd_chk(wdt_pkg::WDT_ADDR_CAUSE, 8'h00);
    rd_chk(16'hFF05, 8'h00);
    rd_chk(SVC, 8'hA5);
    reset_vector_low <= 8'h3C;
    rd_chk(SVC, 8'h3C);
    wr(CFG, 8'h02);
    wr(SVC, 8'h77);
    measure(12200, 12304);
    rd_chk(wdt_pkg::WDT_ADDR_CAUSE, 8'h01);
    rd_chk(wdt_pkg::WDT_ADDR_IRQ_ST, 8'h03);
    check({7'h00, irq}, 8'h00);
    wr(wdt_pkg::WDT_ADDR_IRQ_EN, 8'h01);
    @(posedge clk_sys);
    #1 check({7'h00, irq}, 8'h01);
    wr(wdt_pkg::WDT_ADDR_IRQ_CLR, 8'h03);
    @(posedge clk_sys);
    #1 check({7'h00, irq}, 8'h00);
    rd_chk(wdt_pkg::WDT_ADDR_IRQ_ST, 8'h00);
    wr(wdt_pkg::WDT_ADDR_CAUSE, 8'h00);
    rd_chk(wdt_pkg::WDT_ADDR_CAUSE, 8'h00);
    wr(SVC, 8'hFF);
    measure(8160, 8208);
    wr(SVC, 8'h00);
    sw_on <= 1'b1;
    quiet(9000);
    sw_on <= 1'b0;
    // Each inhibit held longer than one short timeout; last runs long rate
    for (int i = 0; i < 7; i++) begin
      wr(CFG, (i == 5) ? 8'h03 : (i == 6) ? 8'h00 : 8'h02);
      wr(SVC, 8'h00);
      @(posedge clk_sys);
      monitor_mode <= (i < 2);
      irq_pin_high_volt <= (i == 0);
      rst_pin_high_volt <= (i == 1 || i == 2);
      break_active <= (i == 2);
      stop_mode <= (i == 3);
      vector_fetch <= (i == 4);
      quiet(8500);
      @(posedge clk_sys);
      {monitor_mode, irq_pin_high_volt, rst_pin_high_volt} <= '0;
      {break_active, stop_mode, vector_fetch} <= '0;
    end
    results();
  end
endmodule

// *** tb/wdt_sw_model.sv ***
// Software side model: services the watchdog at a steady period.
// Assumes the bench ORs its strobe onto the register write port.
module wdt_sw_model #(
  parameter int PERIOD = 3000
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        active,
  output logic             sw_wr,
  output logic      [15:0] sw_addr,
  output logic      [7:0]  sw_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  //////////////////////////////////////////////////
  // Service from the main loop, well inside one short timeout
  assign sw_addr = wdt_pkg::WDT_ADDR_SERVICE;
  always_ff @(posedge clk_sys) begin
    if (!rst_b || !active) begin
      cnt <= 0;
      sw_wr <= 1'b0;
      sw_wdata <= 8'h00;
    end else if (cnt == PERIOD - 1) begin
      cnt <= 0;
      sw_wr <= 1'b1;
      sw_wdata <= sw_wdata + 8'h01; // Any value clears
    end else begin
      cnt <= cnt + 1;
      sw_wr <= 1'b0;
    end
  end
endmodule

// *** verilog/wdt_core.sv ***
// Watchdog timeout reset: prescaler, watchdog counter, reset pin pulse.
// Assumes clk_sys is the oscillator clock; mode inputs are synchronous.
//
// Summary of operation
// - 6-bit counter clocked by 12-bit prescaler carry
// - Unserviced overflow raises reset after timeout
// - Rate select 1 short, 0 long; reset 0
// - Service write clears counter, prescaler bits 12-5
// - Service read returns reset vector low byte
// - Timeout drives pin low 32 cycles, sets cause
// - Power-on clears prescaler after 4096 cycles
// - Internal reset clears prescaler and counter
// - Reset vector fetch clears prescaler
// - Disable bit 1 stops watchdog, 0 enables
// - Timeout sets event bit 0; CPU interrupt only when enabled
// - Disabled in monitor mode with high voltage
// - Keeps counting in wait mode
// - Stop mode gates clock, clears prescaler
// - Disabled in break with high voltage on pin
// - Counts at oscillator clock rate
//
// The address-and-strobe port is this design's own decision.
module wdt_core (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic [7:0]  reset_vector_low,
  input  wire logic        vector_fetch,
  input  wire logic        stop_mode,
  input  wire logic        monitor_mode,
  input  wire logic        break_active,
  input  wire logic        irq_pin_high_volt,
  input  wire logic        rst_pin_high_volt,
  output logic             rst_pin_out,
  output logic             rst_pin_oe_b,
  output logic             wdt_reset,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin-derived inputs pass two flops first
  logic [1:0] hv_irq_sync;
  logic [1:0] hv_rst_sync;
  always_ff @(posedge clk_sys) begin
    hv_irq_sync <= {hv_irq_sync[0], irq_pin_high_volt};
    hv_rst_sync <= {hv_rst_sync[0], rst_pin_high_volt};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and state
  logic [7:0]                     config_one;
  logic [7:0]                     reset_cause_register;
  logic [1:0]                     irq_status;
  logic [1:0]                     irq_enable;
  logic [wdt_pkg::WDT_PRE_W-1:0]  prescaler;
  logic [wdt_pkg::WDT_WDT_W-1:0]  wdt_count;
  logic [12:0]                    por_count;
  logic                           por_done;
  logic [5:0]                     pulse_count;
  wdt_pkg::wdt_state_type         state;

  // Address decode
  logic sel_service;
  logic sel_config;
  logic sel_cause;
  logic sel_irq_st;
  logic sel_irq_en;
  logic sel_irq_clr;
  assign sel_service = (reg_addr == wdt_pkg::WDT_ADDR_SERVICE);
  assign sel_config  = (reg_addr == wdt_pkg::WDT_ADDR_CONFIG);
  assign sel_cause   = (reg_addr == wdt_pkg::WDT_ADDR_CAUSE);
  assign sel_irq_st  = (reg_addr == wdt_pkg::WDT_ADDR_IRQ_ST);
  assign sel_irq_en  = (reg_addr == wdt_pkg::WDT_ADDR_IRQ_EN);
  assign sel_irq_clr = (reg_addr == wdt_pkg::WDT_ADDR_IRQ_CLR);

  ////////////////////////////////////////////////////////////////////////////
  // Control terms
  logic rate_short;
  logic disabled;
  logic service_wr;
  logic pre_carry;
  logic timeout;
  logic in_pulse;
  assign rate_short = config_one[wdt_pkg::WDT_CFG_RATE];
  // High-voltage test conditions override the configuration bit
  assign disabled = config_one[wdt_pkg::WDT_CFG_DISABLE]
                  | (monitor_mode & (hv_irq_sync[1] | hv_rst_sync[1]))
                  | (break_active & hv_rst_sync[1]);
  assign service_wr = reg_wr & sel_service;
  assign in_pulse   = (state == wdt_pkg::WDT_PULSE);
  // Short rate taps a lower prescaler stage: 2^13 instead of 2^18 span
  assign pre_carry = rate_short
                   ? (&prescaler[wdt_pkg::WDT_SHORT_TAP-1:0])
                   : (&prescaler);
  // Stop mode gates the clock, so neither counter advances
  assign timeout = !disabled && !stop_mode && !in_pulse && pre_carry
                 && (&wdt_count);

  ////////////////////////////////////////////////////////////////////////////
  // Power-on wait before the prescaler is released
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      por_count <= 13'h0000;
      por_done  <= 1'b0;
    end else if (!por_done) begin
      por_count <= por_count + 13'h0001;
      por_done  <= (por_count == 13'(wdt_pkg::WDT_POR_CYC - 1));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler: clears on reset, POR, fetch, stop; service clears bits 12-5
  always_ff @(posedge clk_sys) begin
    if (!rst_b || !por_done || vector_fetch || stop_mode || in_pulse)
      prescaler <= '0;
    else if (service_wr)
      prescaler <= {8'h00, prescaler[3:0] + 4'h1};
    else
      prescaler <= prescaler + 12'h001;
  end

  // Watchdog counter, advanced by the prescaler carry
  always_ff @(posedge clk_sys) begin
    if (!rst_b || disabled || service_wr || in_pulse)
      wdt_count <= '0;
    else if (!stop_mode && por_done && pre_carry)
      wdt_count <= wdt_count + 6'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset pin sequencer; a timeout also sets the cause and event bits
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state       <= wdt_pkg::WDT_RUN;
      pulse_count <= 6'h00;
    end else begin
      case (state)
        wdt_pkg::WDT_RUN: begin
          pulse_count <= 6'h00;
          if (timeout)
            state <= wdt_pkg::WDT_PULSE;
        end
        wdt_pkg::WDT_PULSE: begin
          pulse_count <= pulse_count + 6'h01;
          if (pulse_count == wdt_pkg::WDT_PIN_LOW_LAST)
            state <= wdt_pkg::WDT_RUN;
        end
        default: state <= wdt_pkg::WDT_RUN;
      endcase
    end
  end

  // Open-drain reset pin, driven low while enable is low
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rst_pin_out  <= 1'b1;
      rst_pin_oe_b <= 1'b1;
      wdt_reset    <= 1'b0;
    end else begin
      rst_pin_out  <= 1'b0;
      rst_pin_oe_b <= !(timeout || (in_pulse &&
                      pulse_count != wdt_pkg::WDT_PIN_LOW_LAST));
      wdt_reset    <= timeout || (in_pulse &&
                      pulse_count != wdt_pkg::WDT_PIN_LOW_LAST);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers; cause bit survives the watchdog's own pulse
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      config_one <= wdt_pkg::WDT_CONFIG_RST;
      irq_enable <= wdt_pkg::WDT_IRQ_RST;
    end else if (reg_wr) begin
      if (sel_config)
        config_one <= reg_wdata & 8'h03;
      if (sel_irq_en)
        irq_enable <= reg_wdata[1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b)
      reset_cause_register <= wdt_pkg::WDT_CAUSE_RST;
    else if (timeout)
      reset_cause_register[wdt_pkg::WDT_CAUSE_WDT] <= 1'b1;
    else if (reg_wr && sel_cause)
      reset_cause_register <= 8'h00;
  end

  // Sticky events; a set in the clear cycle wins
  logic [1:0] ev_set;
  logic [1:0] ev_clr;
  assign ev_set = {service_wr, timeout};
  assign ev_clr = (reg_wr && sel_irq_clr) ? reg_wdata[1:0] : 2'h0;
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      irq_status <= wdt_pkg::WDT_IRQ_RST;
      irq        <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~ev_clr) | ev_set;
      irq        <= |(((irq_status & ~ev_clr) | ev_set) & irq_enable);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data one cycle after the strobe
  logic [7:0] rd_mux;
  assign rd_mux = sel_service ? reset_vector_low
                : sel_config  ? config_one
                : sel_cause   ? reset_cause_register
                : sel_irq_st  ? {6'h00, irq_status}
                : sel_irq_en  ? {6'h00, irq_enable}
                : 8'h00;
  always_ff @(posedge clk_sys) begin
    if (!rst_b)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_PULSE_LEN: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $rose(in_pulse) |-> in_pulse [*8]) else $error("pulse too short");
  AST_DIS_NO_RESET: assert property (@(posedge clk_sys) disable iff (!rst_b)
    disabled |-> !timeout) else $error("reset while disabled");
  AST_SERVICE_CLR: assert property (@(posedge clk_sys) disable iff (!rst_b)
    service_wr && !in_pulse |=> wdt_count == 6'h00)
    else $error("service missed");
  AST_CAUSE_SET: assert property (@(posedge clk_sys) disable iff (!rst_b)
    timeout |=> reset_cause_register[0]) else $error("no cause");
  AST_VEC_READ: assert property (@(posedge clk_sys) disable iff (!rst_b)
    reg_rd && sel_service |=> reg_rdata == $past(reset_vector_low))
    else $error("bad vector read");
  AST_FETCH_CLR: assert property (@(posedge clk_sys) disable iff (!rst_b)
    vector_fetch |=> prescaler == 12'h000) else $error("fetch");
  AST_STOP_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_b)
    stop_mode && !service_wr && !disabled && !in_pulse |=> $stable(wdt_count))
    else $error("counts in stop");
  AST_PIN_LOW: assert property (@(posedge clk_sys) disable iff (!rst_b)
    timeout |=> !rst_pin_oe_b) else $error("pin not driven");

  ////////////////////////////////////////////////////////////////////////////
  // Reset pulse steps
  //
  // A timeout is a three-step event. First the comparator sees the counter
  // full while the prescaler carries. Then the pin is held low and the
  // internal reset is raised for the whole pulse. Last the pin is let go
  // and the internal reset drops. The named sequences below
  // spell those steps out so each property reads like the pulse itself.
  // The repetition only covers the first eight cycles of the pulse; the
  // pulse counter check below covers the remaining length, which keeps the
  // unrolled property small.

  // Step one: the comparator fires
  sequence s_timeout_hit;
    timeout;
  endsequence

  // Step two: pin driven low and internal reset raised together
  sequence s_pin_held;
    !rst_pin_oe_b && wdt_reset;
  endsequence

  // Step three: the pin is let go and the internal reset drops
  sequence s_pin_free;
    rst_pin_oe_b && !wdt_reset;
  endsequence

  // The last counted pulse cycle
  sequence s_pulse_last;
    in_pulse && (pulse_count == wdt_pkg::WDT_PIN_LOW_LAST);
  endsequence

  // The pin and the internal reset stay together through the pulse head
  AST_PULSE_BODY: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_timeout_hit |=> s_pin_held [*8])
    else $error("pulse body broken");

  // The pulse ends exactly after its last counted cycle
  AST_PULSE_END: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_pulse_last |=> s_pin_free)
    else $error("pulse did not end");

  // Inside the pulse, before the last count, the pin stays low
  AST_PULSE_MID: assert property (@(posedge clk_sys) disable iff (!rst_b)
    in_pulse && (pulse_count != wdt_pkg::WDT_PIN_LOW_LAST)
      |=> s_pin_held)
    else $error("pin released early");

  ////////////////////////////////////////////////////////////////////////////
  // Counter clearing
  //
  // The prescaler must stay clear until the power-on wait has run out, and
  // stop mode must leave it clear on the next cycle. A service write only
  // clears the upper stages; the low stages keep counting so that a busy
  // service loop cannot stretch the timeout beyond one prescaler tap.

  // Power-on wait keeps the prescaler clear
  AST_PRE_POR: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !por_done |-> prescaler == 12'h000)
    else $error("prescaler ran early");

  // Stop mode clears the prescaler
  AST_STOP_PRE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    stop_mode |=> prescaler == 12'h000)
    else $error("prescaler kept in stop");

  // Service clears the upper prescaler stages
  AST_SERVICE_PRE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    service_wr |=> prescaler[11:4] == 8'h00)
    else $error("upper stages kept");

  // While disabled the counter is held clear
  AST_DIS_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_b)
    disabled |=> wdt_count == 6'h00)
    else $error("counter ran disabled");

  ////////////////////////////////////////////////////////////////////////////
  // Software view
  //
  // The cause bit must survive everything except a write to the cause
  // register, so that software can read the cause after the pulse. The read
  // port returns zero outside the cycle after a read strobe, which keeps a
  // stale value from being mistaken for fresh data. The interrupt output is
  // a level that follows the enabled status bits; a change of the enable
  // register shows one cycle late, so the check skips those cycles.

  // The cause bit is sticky until software writes the cause register
  AST_CAUSE_STICKY: assert property (@(posedge clk_sys) disable iff (!rst_b)
    reset_cause_register[0] && !(reg_wr && sel_cause)
      |=> reset_cause_register[0])
    else $error("cause bit lost");

  // No read strobe, no data
  AST_RDATA_IDLE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data without strobe");

  // Interrupt level follows the enabled status bits
  AST_IRQ_LEVEL: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $stable(irq_enable) |-> irq == |(irq_status & irq_enable))
    else $error("interrupt level wrong");

  ////////////////////////////////////////////////////////////////////////////
  // Notes for the next engineer
  //
  // The timeout figures depend on where a service write lands relative to
  // the low prescaler stages: those stages keep counting across a service,
  // so the time to the next timeout varies by up to sixteen cycles. The
  // first timeout after reset waits for the power-on span as well, since
  // the prescaler is held clear until the power-on wait has run out.
  //
  // The high-voltage inputs pass a two-flop synchroniser, so an inhibit
  // takes effect two cycles after the pin rises. A timeout that falls in
  // those two cycles is not suppressed; a user who raises the test voltage
  // should service the watchdog first.
  //
  // Stop mode freezes the counter rather than clearing it. Software is
  // expected to service the watchdog on entry and exit of stop mode so a
  // full timeout period is available afterwards.

endmodule
